// ---- inc/hdrd_pkg.sv ----
// ------------------------------------------------------------
// Constants for the hub descriptor and request decoder
// ------------------------------------------------------------
package hdrd_pkg;
  // Setup request type bytes and recipient codes (low 7 bits)
  localparam logic [7:0] RT_GET_STD   = 8'h80;
  localparam logic [7:0] RT_GET_CLASS = 8'hA0;
  localparam logic [6:0] RCP_DEV      = 7'h00;
  localparam logic [6:0] RCP_IF       = 7'h01;
  localparam logic [6:0] RCP_EP       = 7'h02;
  // Request codes
  localparam logic [7:0] RQ_CLR_FEAT  = 8'h01;
  localparam logic [7:0] RQ_SET_FEAT  = 8'h03;
  localparam logic [7:0] RQ_GET_DESC  = 8'h06;
  localparam logic [7:0] RQ_GET_CFG   = 8'h08;
  localparam logic [7:0] RQ_SET_CFG   = 8'h09;
  // Feature selector, endpoint indices, config values
  localparam logic [7:0] FEAT_RWU     = 8'h01;
  localparam logic [7:0] EP0_IDX      = 8'h00;
  localparam logic [7:0] EP1_IDX      = 8'h81;
  localparam logic [7:0] CFG_MAX      = 8'h01;
  localparam logic [7:0] GET_CFG_LEN  = 8'h01;
  // Descriptor type codes
  localparam logic [7:0] DT_IF        = 8'h04;
  localparam logic [7:0] DT_EP        = 8'h05;
  localparam logic [7:0] DT_HUB       = 8'h29;
  // Descriptor lengths and placement in the descriptor store
  localparam int         ROM_AW       = 5;
  localparam int         ROM_DEPTH    = 25;
  localparam logic [3:0] IF_LEN       = 4'h9;
  localparam logic [3:0] EP_LEN       = 4'h7;
  localparam logic [3:0] HUB_LEN      = 4'h9;
  localparam logic [4:0] IF_BASE      = 5'h00;
  localparam logic [4:0] EP_BASE      = 5'h09;
  localparam logic [4:0] HUB_BASE     = 5'h10;
  // Power-good time, in 2 ms units within the hub descriptor
  localparam int         PWR_GOOD_MS  = 100;
  localparam int         PWR_UNIT_MS  = 2;
  localparam logic [7:0] PWR_GOOD_B   = 8'(PWR_GOOD_MS / PWR_UNIT_MS);
  localparam logic [7:0] HUB_CURR_MA  = 8'h64;
  // Descriptor store, ascending offsets, two-byte fields low byte first
  localparam logic [0:ROM_DEPTH-1][7:0] DESC_ROM = {
    // Interface: len, type, number, alt, endpoints, class, sub, proto, string
    8'h09, DT_IF, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00, 8'h00, 8'h00,
    // Status-change endpoint only: len, type, addr, attr, size lo/hi, interval
    8'h07, DT_EP, EP1_IDX, 8'h03, 8'h01, 8'h00, 8'hFF,
    // Hub: len, type, ports, characteristics lo/hi, power good, current,
    // removable, power control mask
    8'h09, DT_HUB, 8'h04, 8'h09, 8'h00, PWR_GOOD_B, HUB_CURR_MA, 8'h00, 8'h1E
  };
  // Decoder states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_SEND = 2'b10
  } hdrd_state_e;
endpackage

// ---- src/hdrd_desc_rom.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Descriptor store with registered read data
// ------------------------------------------------------------
module hdrd_desc_rom (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       reset,
  // Read port
  input  wire logic [hdrd_pkg::ROM_AW-1:0] addr,
  output      logic [7:0]                 rdata
);
  import hdrd_pkg::*;

  // Read register; addresses past the end read zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (int'(addr) < ROM_DEPTH) begin
      rdata <= DESC_ROM[addr];
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule // hdrd_desc_rom

// ---- src/hdrd_setup_capture.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Setup packet capture: eight bytes, byte 0 first
// ------------------------------------------------------------
module hdrd_setup_capture (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Byte stream from the serial engine
  input  wire logic        setup_start,
  input  wire logic        setup_valid,
  input  wire logic [7:0]  setup_byte,
  // Assembled packet
  output      logic        setup_done,
  output      logic [63:0] setup_pkt
);
  import hdrd_pkg::*;

  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic        next_done;
  logic [63:0] next_pkt;

  // Byte placement; a ninth byte is dropped until the next start
  always_comb begin
    next_cnt  = cnt;
    next_pkt  = setup_pkt;
    next_done = 1'b0;
    if (setup_start) begin
      next_cnt = 4'h0;
    end else if (setup_valid && !cnt[3]) begin
      next_pkt[cnt[2:0]*8 +: 8] = setup_byte;
      next_cnt                  = cnt + 4'h1;
      next_done                 = (cnt == 4'h7);
    end
  end

  // State registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt        <= 4'h8;
      setup_pkt  <= 64'h0;
      setup_done <= 1'b0;
    end else begin
      cnt        <= next_cnt;
      setup_pkt  <= next_pkt;
      setup_done <= next_done;
    end
  end
endmodule // hdrd_setup_capture

// ---- src/hdrd_request_decoder.sv ----
// Function
// - Interface descriptor: nine bytes, type 04H, one endpoint.
// - Interface number and alternate zero, class 09H, other codes 00H.
// - Endpoint descriptor: seven bytes, type 05H, IN address 81H.
// - Endpoint is interrupt 03H, max packet 01H 00H, interval FFH.
// - No descriptor is served for the default control endpoint.
// - Hub descriptor: nine bytes, type 29H, four downstream ports.
// - Hub characteristics read 09H then 00H.
// - Power-on to power-good byte is 32H, meaning 100 ms.
// - Hub controller current byte is 64H, 100 mA.
// - Removable-device byte is 00H.
// - Port power control mask is 1EH; host powers ports one by one.
// - Requests arrive as eight-byte setup packets decoded field by field.
// - Any unsupported request is answered with STALL.
// - Clear device feature remote wakeup clears the wakeup enable.
// - Clear feature to the interface always stalls.
// - Clear endpoint feature clears EP0 or EP1 stall once cause is gone.
// - Get configuration returns one byte, bit 0 the configured flag.
// - Set configuration takes 00H or 01H with zero rest, else stalls.
// - Descriptors truncate to requested length; shorter ends short.
`timescale 1ns/10ps
module hdrd_request_decoder (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Setup byte stream from the serial engine
  input  wire logic       setup_start,
  input  wire logic       setup_valid,
  input  wire logic [7:0] setup_byte,
  // Data stage towards the host
  input  wire logic       tx_ready,
  output      logic       tx_valid,
  output      logic [7:0] tx_data,
  output      logic       tx_last,
  // Handshake outcome of a setup
  output      logic       stall_pulse,
  output      logic       ack_pulse,
  // Endpoint halt causes, bit 0 EP0, bit 1 EP1
  input  wire logic [1:0] ep_halt_set,
  input  wire logic [1:0] ep_halt_cause,
  // Controller state flags
  output      logic       configured,
  output      logic       remote_wakeup_en,
  output      logic [1:0] ep_stall
);
  import hdrd_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Two-byte field is all zero
  function automatic logic zero16(input logic [15:0] w);
    return (w == 16'h0000);
  endfunction

  // Bytes to send: the smaller of descriptor and requested length
  function automatic logic [3:0] clip(input logic [3:0] dlen,
                                      input logic [15:0] want);
    if (want < {12'h000, dlen}) begin
      return want[3:0];
    end
    return dlen;
  endfunction

  // ------------------------------------------------------------
  // Setup capture and descriptor store
  // ------------------------------------------------------------
  logic        setup_done;
  logic [63:0] pkt;
  logic [4:0]  rom_addr;
  logic [4:0]  next_rom_addr;
  logic [7:0]  rom_q;

  hdrd_setup_capture u_capture (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .setup_start (setup_start),
    .setup_valid (setup_valid),
    .setup_byte  (setup_byte),
    .setup_done  (setup_done),
    .setup_pkt   (pkt)
  );

  // Fixed contents
  // Store is addressed with the next address so its data is ready in LOAD
  hdrd_desc_rom u_rom (
    .sys_clk (sys_clk),
    .reset   (reset),
    .addr    (next_rom_addr),
    .rdata   (rom_q)
  );

  // ------------------------------------------------------------
  // Setup field decode
  // ------------------------------------------------------------
  logic [7:0]  rtype;
  logic [7:0]  req;
  logic [7:0]  val_lo;
  logic [7:0]  val_hi;
  logic [15:0] windex;
  logic [15:0] wlength;
  logic [6:0]  rcp;

  // Multi-byte fields arrive low byte first
  assign rtype   = pkt[7:0];
  assign req     = pkt[15:8];
  assign val_lo  = pkt[23:16];
  assign val_hi  = pkt[31:24];
  assign windex  = pkt[47:32];
  assign wlength = pkt[63:48];
  assign rcp     = rtype[6:0];

  logic       is_clr_dev;
  logic       is_set_dev;
  logic       is_clr_if;
  logic       is_clr_ep;
  logic       is_get_cfg;
  logic       is_set_cfg;
  logic       is_desc;
  logic [4:0] desc_base;
  logic [3:0] desc_len;

  // Request matching; direction bit is ignored where it is a don't-care
  always_comb begin
    is_clr_dev = (rcp == RCP_DEV) && (req == RQ_CLR_FEAT) &&
                 (val_lo == FEAT_RWU) && (val_hi == 8'h00) &&
                 zero16(windex) && zero16(wlength);
    is_set_dev = (rcp == RCP_DEV) && (req == RQ_SET_FEAT) &&
                 (val_lo == FEAT_RWU) && (val_hi == 8'h00) &&
                 zero16(windex) && zero16(wlength);
    is_clr_if  = (rcp == RCP_IF) && (req == RQ_CLR_FEAT);
    is_clr_ep  = (rcp == RCP_EP) && (req == RQ_CLR_FEAT) &&
                 (val_lo == 8'h00) && (val_hi == 8'h00) &&
                 ((windex[7:0] == EP0_IDX) || (windex[7:0] == EP1_IDX)) &&
                 (windex[15:8] == 8'h00) && zero16(wlength);
    is_get_cfg = (rtype == RT_GET_STD) && (req == RQ_GET_CFG) &&
                 (val_lo == 8'h00) && (val_hi == 8'h00) &&
                 zero16(windex) &&
                 (wlength == {8'h00, GET_CFG_LEN});
    is_set_cfg = (rcp == RCP_DEV) && (req == RQ_SET_CFG) &&
                 (val_lo <= CFG_MAX) && (val_hi == 8'h00) &&
                 zero16(windex) && zero16(wlength);
    // Only interface, endpoint1 and hub descriptors live here
    desc_base  = IF_BASE;
    desc_len   = IF_LEN;
    is_desc    = 1'b0;
    if ((req == RQ_GET_DESC) && (val_lo == 8'h00)) begin
      if ((rtype == RT_GET_STD) && (val_hi == DT_IF)) begin
        is_desc = 1'b1;
      end else if ((rtype == RT_GET_STD) && (val_hi == DT_EP)) begin
        is_desc   = 1'b1;
        desc_base = EP_BASE;
        desc_len  = EP_LEN;
      end else if ((rtype == RT_GET_CLASS) && (val_hi == DT_HUB)) begin
        is_desc   = 1'b1;
        desc_base = HUB_BASE;
        desc_len  = HUB_LEN;
      end
    end
  end

  // ------------------------------------------------------------
  // Transfer state machine and controller flags
  // ------------------------------------------------------------
  hdrd_state_e state;
  hdrd_state_e next_state;
  logic [3:0]  remain;
  logic [3:0]  next_remain;
  logic        next_tx_valid;
  logic [7:0]  next_tx_data;
  logic        next_tx_last;
  logic        next_stall;
  logic        next_ack;
  logic        next_configured;
  logic        next_rwu;
  logic [1:0]  next_ep_stall;
  logic [1:0]  ep_clr;
  logic [3:0]  send_cnt;

  // A new setup always aborts a data stage in progress
  always_comb begin
    next_state      = state;
    next_remain     = remain;
    next_rom_addr   = rom_addr;
    next_tx_valid   = tx_valid;
    next_tx_data    = tx_data;
    next_tx_last    = tx_last;
    next_stall      = 1'b0;
    next_ack        = 1'b0;
    next_configured = configured;
    next_rwu        = remote_wakeup_en;
    ep_clr          = 2'b00;
    send_cnt        = clip(desc_len, wlength);
    if (setup_done) begin
      next_tx_valid = 1'b0;
      next_tx_last  = 1'b0;
      next_state    = ST_IDLE;
      if (is_clr_dev) begin
        next_rwu = 1'b0;
        next_ack = 1'b1;
      end else if (is_set_dev) begin
        next_rwu = 1'b1;
        next_ack = 1'b1;
      end else if (is_clr_ep) begin
        // Bit stays set while its cause is still present
        ep_clr[0] = (windex[7:0] == EP0_IDX) && !ep_halt_cause[0];
        ep_clr[1] = (windex[7:0] == EP1_IDX) && !ep_halt_cause[1];
        next_ack  = 1'b1;
      end else if (is_set_cfg) begin
        next_configured = val_lo[0];
        next_ack        = 1'b1;
      end else if (is_get_cfg) begin
        next_tx_data  = {7'h00, configured};
        next_tx_valid = 1'b1;
        next_tx_last  = 1'b1;
        next_remain   = 4'h1;
        next_state    = ST_SEND;
      end else if (is_desc && (send_cnt == 4'h0)) begin
        next_ack = 1'b1;
      end else if (is_desc) begin
        next_rom_addr = desc_base;
        next_remain   = send_cnt;
        next_state    = ST_LOAD;
      end else if (is_clr_if) begin
        next_stall = 1'b1;
      end else begin
        next_stall = 1'b1;
      end
    end else begin
      case (state)
        ST_IDLE: begin
          next_state = ST_IDLE;
        end
        ST_LOAD: begin
          // Store output belongs to rom_addr here
          next_tx_data  = rom_q;
          next_tx_valid = 1'b1;
          next_tx_last  = (remain == 4'h1);
          next_state    = ST_SEND;
        end
        ST_SEND: begin
          if (tx_ready) begin
            next_tx_valid = 1'b0;
            next_tx_last  = 1'b0;
            next_remain   = remain - 4'h1;
            next_rom_addr = rom_addr + 5'h01;
            next_state    = tx_last ? ST_IDLE : ST_LOAD;
          end
        end
        default: begin
          next_state    = ST_IDLE;
          next_tx_valid = 1'b0;
          next_tx_last  = 1'b0;
        end
      endcase
    end
    // Halt events win over a clear in the same cycle
    next_ep_stall = (ep_stall & ~ep_clr) | ep_halt_set;
  end

  // State registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state            <= ST_IDLE;
      remain           <= 4'h0;
      rom_addr         <= 5'h00;
      tx_valid         <= 1'b0;
      tx_data          <= 8'h00;
      tx_last          <= 1'b0;
      stall_pulse      <= 1'b0;
      ack_pulse        <= 1'b0;
      configured       <= 1'b0;
      remote_wakeup_en <= 1'b0;
      ep_stall         <= 2'b00;
    end else begin
      state            <= next_state;
      remain           <= next_remain;
      rom_addr         <= next_rom_addr;
      tx_valid         <= next_tx_valid;
      tx_data          <= next_tx_data;
      tx_last          <= next_tx_last;
      stall_pulse      <= next_stall;
      ack_pulse        <= next_ack;
      configured       <= next_configured;
      remote_wakeup_en <= next_rwu;
      ep_stall         <= next_ep_stall;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  // Setup that requests a descriptor of a given type and length
  sequence s_desc_req(logic [7:0] rt, logic [7:0] dt, logic [3:0] n);
    setup_done && (rtype == rt) && (req == RQ_GET_DESC) &&
    (val_lo == 8'h00) && (val_hi == dt) && (wlength >= {12'h000, n});
  endsequence

  // First byte leaves two cycles after the setup completes
  sequence s_first_byte(logic [7:0] b);
    ##2 (tx_valid && (tx_data == b) && !tx_last);
  endsequence

  a_if_first_byte: assert property (@(posedge sys_clk) disable iff (reset)
    s_desc_req(RT_GET_STD, DT_IF, IF_LEN) |-> s_first_byte(8'h09))
    else $error("interface descriptor did not open with its length");

  a_ep_first_byte: assert property (@(posedge sys_clk) disable iff (reset)
    s_desc_req(RT_GET_STD, DT_EP, EP_LEN) |-> s_first_byte(8'h07))
    else $error("endpoint descriptor did not open with its length");

  a_hub_first_byte: assert property (@(posedge sys_clk) disable iff (reset)
    s_desc_req(RT_GET_CLASS, DT_HUB, HUB_LEN) |-> s_first_byte(8'h09))
    else $error("hub descriptor did not open with its length");

  a_clr_if_stall: assert property (@(posedge sys_clk) disable iff (reset)
    setup_done && (rcp == RCP_IF) && (req == RQ_CLR_FEAT)
    |=> stall_pulse && !ack_pulse && !tx_valid)
    else $error("clear interface feature was not stalled");

  a_rwu_cleared: assert property (@(posedge sys_clk) disable iff (reset)
    setup_done && is_clr_dev |=> !remote_wakeup_en && ack_pulse)
    else $error("remote wakeup enable not cleared");

  a_get_cfg_byte: assert property (@(posedge sys_clk) disable iff (reset)
    setup_done && is_get_cfg |=> tx_valid && tx_last &&
    (tx_data == {7'h00, $past(configured)}))
    else $error("get configuration byte wrong");

  a_set_cfg_value: assert property (@(posedge sys_clk) disable iff (reset)
    setup_done && (rcp == RCP_DEV) && (req == RQ_SET_CFG)
    |=> (stall_pulse && $stable(configured)) ||
        (ack_pulse && (configured == $past(val_lo[0]))))
    else $error("set configuration outcome wrong");

  a_ep1_clear: assert property (@(posedge sys_clk) disable iff (reset)
    setup_done && is_clr_ep && (windex[7:0] == EP1_IDX) &&
    !ep_halt_cause[1] && !ep_halt_set[1] |=> !ep_stall[1])
    else $error("endpoint1 stall bit not cleared");

  a_tx_hold: assert property (@(posedge sys_clk) disable iff (reset)
    tx_valid && !tx_ready && !setup_done
    |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("data byte changed while not accepted");

  a_unknown_stall: assert property (@(posedge sys_clk) disable iff (reset)
    setup_done && (req == 8'h07) |=> stall_pulse)
    else $error("unsupported request not stalled");
endmodule // hdrd_request_decoder

// ---- verification/hdrd_host_model.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Host side: setup sender and data stage sink
// ------------------------------------------------------------
module hdrd_host_model (
  // Clock
  input  wire logic       sys_clk,
  // Setup stream
  output      logic       setup_start,
  output      logic       setup_valid,
  output      logic [7:0] setup_byte,
  // Data stage
  output      logic       tx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  // Handshakes
  input  wire logic       stall_pulse,
  input  wire logic       ack_pulse
);
  logic       slow = 1'b0;
  logic [7:0] rx_q[$];
  int         n_ack = 0;
  int         n_stall = 0;
  int         n_last = 0;
  initial begin
    setup_start = 1'b0;
    setup_valid = 1'b0;
    setup_byte  = 8'h00;
    tx_ready    = 1'b0;
  end
  // Random ready when slow, so the bubble can land anywhere
  always @(negedge sys_clk) begin
    tx_ready <= slow ? 1'($urandom) : 1'b1;
  end
  // Collect accepted bytes and handshakes
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) begin
      rx_q.push_back(tx_data);
      if (tx_last) n_last++;
    end
    if (stall_pulse) n_stall++;
    if (ack_pulse) n_ack++;
  end
  // Eight bytes, byte 0 first, words low byte first
  task automatic send(input logic [63:0] p);
    @(negedge sys_clk);
    setup_start = 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk);
      setup_start = 1'b0;
      setup_valid = 1'b1;
      setup_byte  = p[8*i +: 8];
    end
    @(negedge sys_clk);
    setup_valid = 1'b0;
    setup_byte  = ~setup_byte; // Released line never repeats the last byte
  endtask
endmodule // hdrd_host_model

// ---- verification/hdrd_request_decoder_test.sv ----
`timescale 1ns/10ps
module hdrd_request_decoder_test;
  import hdrd_pkg::*;
  logic       sys_clk, reset, setup_start, setup_valid, tx_ready;
  logic       tx_valid, tx_last, stall_pulse, ack_pulse;
  logic       configured, remote_wakeup_en;
  logic [7:0] setup_byte, tx_data;
  logic [1:0] ep_halt_set, ep_halt_cause, ep_stall;
  int         fail_count = 0;
  int         total_checks = 0;
  // ------------------------------------------------------------
  // Expected descriptor bytes, kept apart from the design store
  // ------------------------------------------------------------
  localparam logic [7:0] EXP [25] = '{
    8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00, 8'h00, 8'h00,
    8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'hFF,
    8'h09, 8'h29, 8'h04, 8'h09, 8'h00, 8'h32, 8'h64, 8'h00, 8'h1E};
  localparam int         DB [3] = '{0, 9, 16};
  localparam int         DL [3] = '{9, 7, 9};
  localparam logic [7:0] TY [3] = '{8'h04, 8'h05, 8'h29};

  hdrd_request_decoder DUT (.sys_clk(sys_clk), .reset(reset), .setup_start(setup_start),
    .setup_valid(setup_valid), .setup_byte(setup_byte), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .stall_pulse(stall_pulse),
    .ack_pulse(ack_pulse), .ep_halt_set(ep_halt_set), .ep_halt_cause(ep_halt_cause),
    .configured(configured), .remote_wakeup_en(remote_wakeup_en), .ep_stall(ep_stall));
  hdrd_host_model host (.sys_clk(sys_clk), .setup_start(setup_start),
    .setup_valid(setup_valid), .setup_byte(setup_byte), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .stall_pulse(stall_pulse), .ack_pulse(ack_pulse));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Words go in low byte first, as the host sends them
  function automatic logic [63:0] mk(input logic [7:0] b0, b1, input logic [15:0] v, x, n);
    return {n, x, v, b1, b0};
  endfunction
  // Bytes the host should see: the descriptor cut to the requested length
  function automatic int exp_len(input int want, input int dlen);
    return (want < dlen) ? want : dlen;
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Answer kind: 1 ack, 2 stall, 3 data ended; bounded wait
  task automatic req(input logic [63:0] p, output int kind);
    int a, s, l;
    a = host.n_ack;
    s = host.n_stall;
    l = host.n_last;
    host.rx_q.delete();
    host.send(p);
    kind = 0;
    for (int i = 0; i < 300 && kind == 0; i++) begin
      @(negedge sys_clk);
      if (host.n_ack != a) kind = 1;
      else if (host.n_stall != s) kind = 2;
      else if (host.n_last != l) kind = 3;
    end
    if (kind == 0) begin
      fail_count++;
      $display("wrong value answer expected some seen none");
      close_out();
    end else begin
      repeat (2) @(negedge sys_clk);
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int kind, len, n;
    logic [7:0] e;
    reset = 1'b1;
    ep_halt_set = 2'b00;
    ep_halt_cause = 2'b00;
    void'($urandom(41697));
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    // Descriptors: zero, exact, oversize and random truncated lengths
    for (int t = 0; t < 3; t++) begin
      for (int k = 0; k < 4; k++) begin
        len = (k == 0) ? 0 : (k == 1) ? DL[t] : (k == 2) ? 40 : $urandom_range(DL[t] - 1, 1);
        host.slow = 1'(k);
        req(mk((t == 2) ? 8'hA0 : 8'h80, 8'h06, {TY[t], 8'h00}, 16'h0000, 16'(len)), kind);
        n = exp_len(len, DL[t]);
        chk("desc answer", (len == 0) ? 8'h01 : 8'h03, 8'(kind));
        chk("desc count", 8'(n), 8'(host.rx_q.size()));
        for (int i = 0; i < host.rx_q.size(); i++) begin
          e = EXP[DB[t] + i];
          if (t == 0) chk("if byte", e, host.rx_q[i]);
          else if (t == 1) chk("ep byte", e, host.rx_q[i]);
          else chk("hub byte", e, host.rx_q[i]);
        end
      end
    end
    host.slow = 1'b0;
    $display("test descriptors done");
    // Remote wakeup set then cleared, byte 0 bit 7 random on the clear
    req(mk(8'h00, 8'h03, 16'h0001, 16'h0000, 16'h0000), kind);
    chk("wakeup set", 8'h01, {7'h00, remote_wakeup_en});
    req(mk({1'($urandom), 7'h00}, 8'h01, 16'h0001, 16'h0000, 16'h0000), kind);
    chk("wakeup ack", 8'h01, 8'(kind));
    chk("wakeup clr", 8'h00, {7'h00, remote_wakeup_en});
    // Interface clear feature stalls whatever follows
    for (int i = 0; i < 4; i++) begin
      req(mk({1'($urandom), 7'h01}, 8'h01, 16'($urandom), 16'($urandom), 16'($urandom)), kind);
      chk("if clear", 8'h02, 8'(kind));
    end
    $display("test features done");
    // Configuration: accepted values, refused values, readback
    req(mk(8'h00, 8'h09, 16'h0001, 16'h0000, 16'h0000), kind);
    chk("cfg set", 8'h01, {7'h00, configured});
    req(mk(8'h80, 8'h08, 16'h0000, 16'h0000, 16'h0001), kind);
    chk("cfg get", 8'h01, (host.rx_q.size() == 1) ? host.rx_q[0] : 8'hEE);
    req(mk(8'h00, 8'h09, 16'h0002, 16'h0000, 16'h0000), kind);
    chk("cfg bad", 8'h02, 8'(kind));
    req(mk(8'h00, 8'h09, 16'h0000, 16'h0001, 16'h0000), kind);
    chk("cfg bad idx", 8'h02, 8'(kind));
    chk("cfg kept", 8'h01, {7'h00, configured});
    req(mk(8'h00, 8'h09, 16'h0000, 16'h0000, 16'h0000), kind);
    req(mk(8'h80, 8'h08, 16'h0000, 16'h0000, 16'h0001), kind);
    chk("cfg get 0", 8'h00, (host.rx_q.size() == 1) ? host.rx_q[0] : 8'hEE);
    req(mk(8'h00, 8'h07, 16'($urandom), 16'($urandom), 16'($urandom)), kind);
    chk("set desc", 8'h02, 8'(kind));
    $display("test config done");
    // Endpoint stall bit survives a clear while its cause is present
    for (int ep = 0; ep < 2; ep++) begin
      ep_halt_set = 2'(1 << ep);
      ep_halt_cause = 2'(1 << ep);
      @(negedge sys_clk);
      ep_halt_set = 2'b00;
      req(mk(8'h02, 8'h01, 16'h0000, ep ? 16'h0081 : 16'h0000, 16'h0000), kind);
      chk("ep kept", {6'h00, 2'(1 << ep)}, {6'h00, ep_stall});
      ep_halt_cause = 2'b00;
      req(mk(8'h02, 8'h01, 16'h0000, ep ? 16'h0081 : 16'h0000, 16'h0000), kind);
      chk("ep clear", 8'h00, {6'h00, ep_stall});
    end
    $display("test endpoints done");
    close_out();
  end
endmodule // hdrd_request_decoder_test
